// *** tmr8_pkg.sv ***
// tmr8_pkg: register map, field positions and encodings of the 8-bit timer
`default_nettype none
package tmr8_pkg;
    // register byte addresses on the register bus
    localparam logic [7:0] tmr8_addr_ctrl_a = 8'h00;
    localparam logic [7:0] tmr8_addr_ctrl_b = 8'h04;
    localparam logic [7:0] tmr8_addr_count = 8'h08;
    localparam logic [7:0] tmr8_addr_cmp_a = 8'h0c;
    localparam logic [7:0] tmr8_addr_cmp_b = 8'h10;
    localparam logic [7:0] tmr8_addr_mask = 8'h14;
    localparam logic [7:0] tmr8_addr_flags = 8'h18;
    localparam logic [7:0] tmr8_addr_ack = 8'h1c;
    // control b fields
    localparam int tmr8_pos_force_a = 7;
    localparam int tmr8_pos_force_b = 6;
    localparam int tmr8_pos_wave_bit2 = 3;
    // flag and mask bit positions
    localparam int tmr8_pos_cmp_b = 2;
    localparam int tmr8_pos_cmp_a = 1;
    localparam int tmr8_pos_ovf = 0;
    // reset values
    localparam logic [7:0] tmr8_rst_reg = 8'h00;
    localparam logic [9:0] tmr8_rst_presc = 10'h000;
    // prescaler tap masks: tap fires when masked count bits are all ones
    localparam logic [9:0] tmr8_tap_8 = 10'h007;
    localparam logic [9:0] tmr8_tap_64 = 10'h03f;
    localparam logic [9:0] tmr8_tap_256 = 10'h0ff;
    localparam logic [9:0] tmr8_tap_1024 = 10'h3ff;
    // fixed top value
    localparam logic [7:0] tmr8_max = 8'hff;
    localparam logic [7:0] tmr8_bottom = 8'h00;
    // clock select encodings
    localparam logic [2:0] tmr8_cs_stop = 3'h0;
    localparam logic [2:0] tmr8_cs_div1 = 3'h1;
    localparam logic [2:0] tmr8_cs_div8 = 3'h2;
    localparam logic [2:0] tmr8_cs_div64 = 3'h3;
    localparam logic [2:0] tmr8_cs_div256 = 3'h4;
    localparam logic [2:0] tmr8_cs_div1024 = 3'h5;
    localparam logic [2:0] tmr8_cs_ext_fall = 3'h6;
    localparam logic [2:0] tmr8_cs_ext_rise = 3'h7;
    // waveform modes
    localparam logic [2:0] tmr8_wm_normal = 3'h0;
    localparam logic [2:0] tmr8_wm_pc_ff = 3'h1;
    localparam logic [2:0] tmr8_wm_clear_match = 3'h2;
    localparam logic [2:0] tmr8_wm_fast_ff = 3'h3;
    localparam logic [2:0] tmr8_wm_pc_a = 3'h5;
    localparam logic [2:0] tmr8_wm_fast_a = 3'h7;
    // compare output modes
    localparam logic [1:0] tmr8_com_off = 2'h0;
    localparam logic [1:0] tmr8_com_toggle = 2'h1;
    localparam logic [1:0] tmr8_com_clear = 2'h2;
    localparam logic [1:0] tmr8_com_set = 2'h3;
    // axi responses
    localparam logic [1:0] tmr8_resp_okay = 2'h0;
    localparam logic [1:0] tmr8_resp_slverr = 2'h2;
    // counter direction in phase-correct modes
    typedef enum logic [1:0] {
        tmr8_dir_up = 2'b01,
        tmr8_dir_down = 2'b10
    } tmr8_dir_t;
endpackage
`default_nettype wire

// *** tmr8_timer.sv ***
// tmr8_timer: 8-bit timer/counter with two compare channels on axi4-lite
//
// Behaviour
// - force bits act only in non-pwm modes; software writes zero in pwm
// - force strobe applies a compare match to the output using mode bits
// - forced compare sets no flag and never clears the counter
// - force bits are write-only and read back as zero
// - clock select 0 stops, 1 undivided, 2..5 divide 8/64/256/1024
// - select 6 counts falling pin edges, 7 counts rising pin edges
// - pin edges count even while the pin is driven as an output
// - counter is read/write; a write blocks next timer-clock match
// - both compare registers compared continuously with the counter
// - mask bit 2 enables the channel b compare interrupt
// - mask bit 1 enables the channel a compare interrupt
// - mask bit 0 enables the overflow interrupt
// - flag bit 2 set on b match, cleared by vector or writing one
// - flag bit 1 set on a match, cleared by vector or writing one
// - flag bit 0 set on overflow per mode, cleared by vector or one
// - reserved control b and mask/flag bits ignore writes, read zero
// - control b bit 3 is the top waveform mode bit
// - mode selects normal, phase pwm, clear-on-match, fast pwm variants
// - non-pwm output modes: off, toggle, clear, set on match
`timescale 1ns/100ps
`default_nettype none
module tmr8_timer (
    input wire logic clock, // 25 mhz io clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic ext_count_pin, // external count input
    input wire logic [2:0] vector_ack, // vector taken: b, a, overflow
    output logic wave_out_a, // channel a waveform
    output logic wave_out_b, // channel b waveform
    output logic wave_en_a, // channel a pin override
    output logic wave_en_b, // channel b pin override
    output logic [2:0] irq_req // requests: b, a, overflow
);
    import tmr8_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] output_mode_a;
    logic [1:0] output_mode_b;
    logic [1:0] wave_mode_low_bits;
    logic wave_mode_bit2;
    logic [2:0] clock_select_field;
    logic [7:0] timer_count_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [2:0] timer_irq_mask;
    logic [2:0] timer_irq_flags;
    logic [9:0] presc;
    logic pin_q;
    logic block_match;
    tmr8_dir_t dir;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go, wr_lane0;
    logic rd_go;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0 = wr_go && w_strb[0];
    assign rd_go = s_axi_arvalid && s_axi_arready;

    // capture address and data in either order
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    logic wr_known;
    always_comb begin
        case (aw_addr)
            tmr8_addr_ctrl_a, tmr8_addr_ctrl_b, tmr8_addr_count,
            tmr8_addr_cmp_a, tmr8_addr_cmp_b, tmr8_addr_mask,
            tmr8_addr_flags, tmr8_addr_ack: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // write response
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tmr8_resp_okay;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? tmr8_resp_okay : tmr8_resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_ctrl_a, wr_ctrl_b, wr_count, wr_flags;
    assign wr_ctrl_a = wr_lane0 && aw_addr == tmr8_addr_ctrl_a;
    assign wr_ctrl_b = wr_lane0 && aw_addr == tmr8_addr_ctrl_b;
    assign wr_count = wr_lane0 && aw_addr == tmr8_addr_count;
    assign wr_flags = wr_lane0 && aw_addr == tmr8_addr_flags;

    // plain configuration registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            output_mode_a <= tmr8_com_off;
            output_mode_b <= tmr8_com_off;
            wave_mode_low_bits <= 2'h0;
            wave_mode_bit2 <= 1'b0;
            clock_select_field <= tmr8_cs_stop;
            compare_value_a <= tmr8_rst_reg;
            compare_value_b <= tmr8_rst_reg;
            timer_irq_mask <= 3'h0;
        end else begin
            if (wr_ctrl_a) begin
                output_mode_a <= w_data[7:6];
                output_mode_b <= w_data[5:4];
                wave_mode_low_bits <= w_data[1:0];
            end
            if (wr_ctrl_b) begin
                wave_mode_bit2 <= w_data[tmr8_pos_wave_bit2];
                clock_select_field <= w_data[2:0];
            end
            if (wr_lane0 && aw_addr == tmr8_addr_cmp_a)
                compare_value_a <= w_data[7:0];
            if (wr_lane0 && aw_addr == tmr8_addr_cmp_b)
                compare_value_b <= w_data[7:0];
            if (wr_lane0 && aw_addr == tmr8_addr_mask)
                timer_irq_mask <= w_data[2:0];
        end
    end

    // read data; force and reserved bits read zero
    logic [7:0] rd_byte;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        case (s_axi_araddr)
            tmr8_addr_ctrl_a: rd_byte = {output_mode_a, output_mode_b,
                2'b00, wave_mode_low_bits};
            tmr8_addr_ctrl_b: rd_byte = {4'h0, wave_mode_bit2,
                clock_select_field};
            tmr8_addr_count: rd_byte = timer_count_value;
            tmr8_addr_cmp_a: rd_byte = compare_value_a;
            tmr8_addr_cmp_b: rd_byte = compare_value_b;
            tmr8_addr_mask: rd_byte = {5'h00, timer_irq_mask};
            tmr8_addr_flags: rd_byte = {5'h00, timer_irq_flags};
            tmr8_addr_ack: rd_byte = 8'h00;
            default: begin
                rd_byte = 8'h00;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tmr8_resp_okay;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_known ? tmr8_resp_okay : tmr8_resp_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // clock select and prescaler
    // ------------------------------------------------------------
    logic [2:0] wave_mode;
    logic pwm_mode, top_is_a, tick;
    assign wave_mode = {wave_mode_bit2, wave_mode_low_bits};
    assign pwm_mode = wave_mode != tmr8_wm_normal
        && wave_mode != tmr8_wm_clear_match;
    assign top_is_a = wave_mode == tmr8_wm_clear_match
        || wave_mode == tmr8_wm_pc_a || wave_mode == tmr8_wm_fast_a;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            presc <= tmr8_rst_presc;
            pin_q <= 1'b0;
        end else begin
            presc <= presc + 10'h001;
            pin_q <= ext_count_pin;
        end
    end

    always_comb begin
        case (clock_select_field)
            tmr8_cs_div1: tick = 1'b1;
            tmr8_cs_div8: tick = (presc & tmr8_tap_8) == tmr8_tap_8;
            tmr8_cs_div64: tick = (presc & tmr8_tap_64) == tmr8_tap_64;
            tmr8_cs_div256: tick = (presc & tmr8_tap_256) == tmr8_tap_256;
            tmr8_cs_div1024: tick = presc == tmr8_tap_1024;
            tmr8_cs_ext_fall: tick = pin_q && !ext_count_pin;
            tmr8_cs_ext_rise: tick = !pin_q && ext_count_pin;
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic [7:0] top;
    logic at_top, at_bottom, match_a, match_b;
    assign top = top_is_a ? compare_value_a : tmr8_max;
    assign at_top = timer_count_value == top;
    assign at_bottom = timer_count_value == tmr8_bottom;
    assign match_a = tick && !block_match
        && timer_count_value == compare_value_a;
    assign match_b = tick && !block_match
        && timer_count_value == compare_value_b;
    logic phase_mode;
    assign phase_mode = wave_mode == tmr8_wm_pc_ff
        || wave_mode == tmr8_wm_pc_a;

    always_ff @(posedge clock) begin
        if (!reset_n)
            block_match <= 1'b0;
        else if (wr_count)
            block_match <= 1'b1;
        else if (tick)
            block_match <= 1'b0;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            timer_count_value <= tmr8_rst_reg;
            dir <= tmr8_dir_up;
        end else if (wr_count) begin
            timer_count_value <= w_data[7:0];
        end else if (tick) begin
            if (phase_mode) begin
                if (dir == tmr8_dir_up && at_top) begin
                    dir <= tmr8_dir_down;
                    timer_count_value <= timer_count_value - 8'h01;
                end else if (dir == tmr8_dir_down && at_bottom) begin
                    dir <= tmr8_dir_up;
                    timer_count_value <= timer_count_value + 8'h01;
                end else if (dir == tmr8_dir_up) begin
                    timer_count_value <= timer_count_value + 8'h01;
                end else begin
                    timer_count_value <= timer_count_value - 8'h01;
                end
            end else begin
                dir <= tmr8_dir_up;
                timer_count_value <= at_top ? tmr8_bottom
                    : timer_count_value + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    logic ovf_evt;
    always_comb begin
        if (phase_mode)
            ovf_evt = tick && at_bottom && dir == tmr8_dir_down;
        else if (wave_mode == tmr8_wm_fast_a)
            ovf_evt = tick && at_top;
        else
            ovf_evt = tick && timer_count_value == tmr8_max;
    end

    logic [2:0] flag_set, flag_clr;
    assign flag_set = {match_b, match_a, ovf_evt};
    assign flag_clr = vector_ack | (wr_flags ? w_data[2:0] : 3'h0);

    always_ff @(posedge clock) begin
        if (!reset_n)
            timer_irq_flags <= 3'h0;
        else
            timer_irq_flags <= flag_set | (timer_irq_flags & ~flag_clr);
    end

    assign irq_req = timer_irq_flags & timer_irq_mask;

    // ------------------------------------------------------------
    // waveform outputs
    // ------------------------------------------------------------
    logic force_a, force_b;
    assign force_a = wr_ctrl_b && w_data[tmr8_pos_force_a] && !pwm_mode;
    assign force_b = wr_ctrl_b && w_data[tmr8_pos_force_b] && !pwm_mode;

    function automatic logic wave_next(input logic cur,
            input logic [1:0] com);
        case (com)
            tmr8_com_toggle: wave_next = !cur;
            tmr8_com_clear: wave_next = 1'b0;
            tmr8_com_set: wave_next = 1'b1;
            default: wave_next = cur;
        endcase
    endfunction

    // match or forced strobe drives output, in non-pwm modes only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end else begin
            if (force_a || (match_a && !pwm_mode))
                wave_out_a <= wave_next(wave_out_a, output_mode_a);
            if (force_b || (match_b && !pwm_mode))
                wave_out_b <= wave_next(wave_out_b, output_mode_b);
        end
    end

    assign wave_en_a = output_mode_a != tmr8_com_off;
    assign wave_en_b = output_mode_b != tmr8_com_off;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    force_no_flag_a: assert property (
        force_a && !match_a && !(wr_flags && w_data[1]) && !vector_ack[1]
        |=> timer_irq_flags[1] == $past(timer_irq_flags[1]))
        else $error("forced compare changed flag a");
    force_pwm_a: assert property (
        wr_ctrl_b && pwm_mode && !match_a |=> $stable(wave_out_a))
        else $error("force acted in pwm mode");
    force_read_a: assert property (
        s_axi_rvalid && $past(rd_go && s_axi_araddr == tmr8_addr_ctrl_b)
        |-> s_axi_rdata[7:4] == 4'h0)
        else $error("force bits read non-zero");
    stop_hold_a: assert property (
        clock_select_field == tmr8_cs_stop && !wr_count
        |=> $stable(timer_count_value))
        else $error("stopped counter moved");
    block_match_a: assert property (
        wr_count |=> !match_a && !match_b)
        else $error("match after counter write");
    flag_set_a: assert property (
        match_a |=> timer_irq_flags[1])
        else $error("match a did not set flag");
    flag_clear_a: assert property (
        timer_irq_flags[2] && wr_flags && w_data[2] && !match_b
        |=> !timer_irq_flags[2])
        else $error("flag b not cleared by one");
    irq_gate_a: assert property (
        ovf_evt && timer_irq_mask[0]
        && !(wr_lane0 && aw_addr == tmr8_addr_mask) |=> irq_req[0])
        else $error("overflow request missing");
    ext_rise_a: assert property (
        clock_select_field == tmr8_cs_ext_rise && !wr_count
        && !pin_q && ext_count_pin && !phase_mode && !at_top
        |=> timer_count_value == $past(timer_count_value) + 8'h01)
        else $error("rising pin edge not counted");

    cov_force_c: cover property (force_a && output_mode_a == tmr8_com_toggle);
    cov_ovf_c: cover property (ovf_evt && timer_irq_mask[0]);
    cov_clear_c: cover property (wave_mode == tmr8_wm_clear_match && match_a);
endmodule // tmr8_timer
`default_nettype wire

// *** tmr8_cpu_model.sv ***
// tmr8_cpu_model: cpu side that takes timer interrupt vectors
`timescale 1ns/100ps
`default_nettype none
module tmr8_cpu_model (
    input wire logic clock, // io clock
    input wire logic reset_n, // sync reset, active low
    input wire logic [2:0] irq_req, // requests: b, a, overflow
    input wire logic global_en, // global interrupt enable
    output logic [2:0] vector_ack // one-cycle vector taken
);
    // one vector at a time, overflow first, then a, then b
    // vector when enabled
    always_ff @(posedge clock) begin
        if (!reset_n || vector_ack != 3'h0) begin
            vector_ack <= 3'h0;
        end else if (global_en) begin
            vector_ack <= irq_req & ~(irq_req - 3'h1);
        end
    end
endmodule // tmr8_cpu_model
`default_nettype wire

// *** tb_top.sv ***
// tb_top: register-level tests of the 8-bit timer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import tmr8_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic pin = 1'b0;
    logic ge = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, wa, wb, ea, eb;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata;
    logic [2:0] ack, irq;
    logic [7:0] d, q;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int divs[5] = '{1, 8, 64, 256, 1024};
    logic [23:0] ft[8] = '{24'h408002, 24'h808000, 24'hc08002,
        24'h838002, 24'h428000, 24'h104001, 24'h134001, 24'h104000};
    tmr8_timer uut (.clock(clock), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .ext_count_pin(pin), .vector_ack(ack), .wave_out_a(wa),
        .wave_out_b(wb), .wave_en_a(ea), .wave_en_b(eb), .irq_req(irq));
    tmr8_cpu_model cpu (.clock(clock), .reset_n(reset_n), .irq_req(irq),
        .global_en(ge), .vector_ack(ack));
    // clock and hang guard
    initial forever #20 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            final_report;
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // axi4-lite write, address and data released as each is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata[7:0];
        r = rresp;
    endtask
    // short undivided run from a start count, m is the top mode bit
    task automatic tick(input logic [7:0] s, input logic m = 1'b0);
        wr(tmr8_addr_count, s);
        wr(tmr8_addr_ctrl_b, {4'h0, m, tmr8_cs_div1});
        repeat (4) @(posedge clock);
        wr(tmr8_addr_ctrl_b, 8'h00);
    endtask
    task automatic pulse;
        pin <= 1'b1;
        repeat (2) @(posedge clock);
        pin <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(tmr8_addr_ctrl_b, d); chk(d, 8'h00);
        rd(tmr8_addr_mask, d); chk(d, 8'h00);
        rd(tmr8_addr_cmp_a, d); chk(d, 8'h00);
        wr(tmr8_addr_ctrl_b, 8'hf0);
        rd(tmr8_addr_ctrl_b, d); chk(d, 8'h00);
        wr(tmr8_addr_ctrl_b, 8'h08);
        rd(tmr8_addr_ctrl_b, d); chk(d, 8'h08);
        wr(tmr8_addr_ctrl_b, 8'h00);
        wr(tmr8_addr_mask, 8'hff);
        rd(tmr8_addr_mask, d); chk(d, 8'h07);
        wr(8'h20, 8'h55); chk(r, tmr8_resp_slverr);
        rd(8'h20, d); chk({r, d}, {tmr8_resp_slverr, 8'h00});
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            wr(tmr8_addr_count, 8'h00);
            wr(tmr8_addr_ctrl_b, 8'(i + 1));
            repeat (divs[i] * 8) @(posedge clock);
            wr(tmr8_addr_ctrl_b, 8'h00);
            rd(tmr8_addr_count, d);
            chk(d >= 7 && d <= 13, 1);
            repeat (40) @(posedge clock);
            rd(tmr8_addr_count, q); chk(q, d);
        end
        $display("test prescaler done");
        wr(tmr8_addr_count, 8'h00);
        wr(tmr8_addr_ctrl_b, {5'h0, tmr8_cs_ext_rise});
        repeat (5) pulse;
        wr(tmr8_addr_ctrl_b, {5'h0, tmr8_cs_ext_fall});
        repeat (5) pulse;
        wr(tmr8_addr_ctrl_b, 8'h00);
        rd(tmr8_addr_count, d); chk(d, 8'h0a);
        $display("test pin count done");
        wr(tmr8_addr_cmp_a, 8'h10);
        wr(tmr8_addr_cmp_b, 8'h11);
        wr(tmr8_addr_flags, 8'h07);
        wr(tmr8_addr_mask, 8'h07);
        tick(8'h10);
        rd(tmr8_addr_flags, d); chk(d, 8'h04);
        chk(irq, 3'b100);
        wr(tmr8_addr_flags, 8'h04);
        rd(tmr8_addr_flags, d); chk(d, 8'h00);
        tick(8'h0e);
        rd(tmr8_addr_flags, d); chk(d, 8'h06);
        wr(tmr8_addr_mask, 8'h02); chk(irq, 3'b010);
        tick(8'hfe);
        rd(tmr8_addr_flags, d); chk(d, 8'h07);
        wr(tmr8_addr_mask, 8'h01); chk(irq, 3'b001);
        ge <= 1'b1;
        repeat (4) @(posedge clock);
        rd(tmr8_addr_flags, d); chk(d, 8'h06);
        wr(tmr8_addr_mask, 8'h07);
        repeat (6) @(posedge clock);
        rd(tmr8_addr_flags, d); chk(d, 8'h00);
        ge <= 1'b0;
        $display("test flags done");
        wr(tmr8_addr_ctrl_a, 8'h02);
        tick(8'h0e);
        rd(tmr8_addr_count, d); chk(d, 8'h04);
        rd(tmr8_addr_flags, d); chk(d, 8'h02);
        wr(tmr8_addr_flags, 8'h07);
        wr(tmr8_addr_cmp_a, 8'h02);
        wr(tmr8_addr_ctrl_a, 8'h01);
        tick(8'h01, 1'b1);
        rd(tmr8_addr_count, d); chk(d, 8'h00);
        rd(tmr8_addr_flags, d); chk(d, 8'h03);
        wr(tmr8_addr_flags, 8'h07);
        wr(tmr8_addr_ctrl_a, 8'h03);
        tick(8'h01, 1'b1);
        rd(tmr8_addr_count, d); chk(d, 8'h02);
        rd(tmr8_addr_flags, d); chk(d, 8'h03);
        wr(tmr8_addr_flags, 8'h07);
        $display("test wave modes done");
        wr(tmr8_addr_count, 8'h33);
        for (int i = 0; i < 8; i++) begin
            wr(tmr8_addr_ctrl_a, ft[i][23:16]);
            wr(tmr8_addr_ctrl_b, ft[i][15:8]);
            chk({wa, wb}, ft[i][1:0]);
            chk({ea, eb}, {|ft[i][23:22], |ft[i][21:20]});
        end
        rd(tmr8_addr_flags, d); chk(d, 8'h00);
        rd(tmr8_addr_count, d); chk(d, 8'h33);
        rd(tmr8_addr_ctrl_b, d); chk(d, 8'h00);
        $display("test force done");
        final_report;
    end
endmodule // tb_top
`default_nettype wire
